// ==== nsl_pkg.sv ====
// Constants, register map and types of the network status lamp driver
package nsl_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS     = 100;
    localparam int MS_NS             = 1_000_000;
    localparam int MS_CYCLES         = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Lamp pattern timing, in milliseconds
    localparam int BLINK_HALF_MS     = 200;
    localparam int FLASH_ON_MS       = 200;
    localparam int FLASH_OFF_MS      = 1000;
    localparam int FLICKER_PERIOD_MS = 50;
    localparam int FLICKER_HALF_MS   = FLICKER_PERIOD_MS / 2;
    localparam int FLASH_OFF_SLOTS   = FLASH_OFF_MS / FLASH_ON_MS;
    localparam int ACT_HOLD_MS       = FLICKER_PERIOD_MS;
    localparam int NUM_FLASH         = 3;

    localparam int NUM_PORTS         = 2;
    localparam int NUM_LAMPS         = 5;

    // Register byte addresses
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0]  ADDR_FORCE    = 8'h10;

    // Control register
    localparam int          CTRL_EN_BIT   = 0;
    localparam logic [0:0]  CTRL_RESET    = 1'h1;

    // Interrupt status and mask layout
    localparam int          IRQ_W         = 5;
    localparam int          IRQ_LINK_LSB  = 0;
    localparam int          IRQ_SYS       = 2;
    localparam int          IRQ_BUS       = 3;
    localparam int          IRQ_UV        = 4;
    localparam logic [4:0]  IRQ_RESET     = 5'h00;

    // Status register layout
    localparam int          ST_IN_W       = 10;
    localparam int          ST_LAMP_LSB   = 16;
    localparam int          ST_LAMP_W     = 6;

    // Lamp force register: one mode field per lamp
    localparam int          MODE_W        = 3;
    localparam int          FORCE_W       = NUM_LAMPS * MODE_W;
    localparam int          LAMP_LINK0    = 0;
    localparam int          LAMP_SYS      = 2;
    localparam int          LAMP_BUS      = 3;
    localparam int          LAMP_PWR      = 4;
    localparam logic [14:0] FORCE_RESET   = 15'h0000;

    typedef enum logic [2:0] {
        MODE_AUTO    = 3'h0,
        MODE_OFF     = 3'h1,
        MODE_ON      = 3'h2,
        MODE_BLINK   = 3'h3,
        MODE_FLASH1  = 3'h4,
        MODE_FLASH2  = 3'h5,
        MODE_FLASH3  = 3'h6,
        MODE_FLICKER = 3'h7
    } nsl_mode_t;

endpackage

// ==== nsl_pattern_gen.sv ====
// Free-running blink, flash and flicker pattern generator
`timescale 1ns/1ps
`default_nettype none
module nsl_pattern_gen
    import nsl_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ms_tick,
    output logic                      blink,
    output logic                      flicker,
    output logic [NUM_FLASH-1:0]      flash
);
    localparam int SW = $clog2(FLASH_ON_MS);
    localparam int FW = $clog2(FLICKER_HALF_MS);

    logic [SW-1:0] slot_ms_reg, slot_ms_next;
    logic [FW-1:0] flk_ms_reg, flk_ms_next;
    logic          blink_reg, blink_next;
    logic          flk_reg, flk_next;
    logic          slot_tick;

    always_comb begin
        slot_tick    = ms_tick && (slot_ms_reg == SW'(FLASH_ON_MS - 1));
        slot_ms_next = slot_ms_reg;
        flk_ms_next  = flk_ms_reg;
        blink_next   = blink_reg;
        flk_next     = flk_reg;
        if (ms_tick) begin
            slot_ms_next = slot_tick ? '0 : slot_ms_reg + 1'b1;
            if (flk_ms_reg == FW'(FLICKER_HALF_MS - 1)) begin
                flk_ms_next = '0;
                flk_next    = !flk_reg;
            end else begin
                flk_ms_next = flk_ms_reg + 1'b1;
            end
        end
        // Flash on time and blink half period share one 200 ms slot
        if (slot_tick && (BLINK_HALF_MS == FLASH_ON_MS)) begin
            blink_next = !blink_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_ms_reg <= '0;
            flk_ms_reg  <= '0;
            blink_reg   <= 1'b0;
            flk_reg     <= 1'b0;
        end else begin
            slot_ms_reg <= slot_ms_next;
            flk_ms_reg  <= flk_ms_next;
            blink_reg   <= blink_next;
            flk_reg     <= flk_next;
        end
    end

    // Flash n: n lit slots separated by dark slots, then a 1 s dark tail
    for (genvar n = 1; n <= NUM_FLASH; n++) begin : g_flash
        localparam int SLOTS = 2 * n - 1 + FLASH_OFF_SLOTS;
        logic [3:0] cnt_reg, cnt_next;
        logic       lit_reg, lit_next;
        always_comb begin
            cnt_next = cnt_reg;
            if (slot_tick) begin
                cnt_next = (cnt_reg == 4'(SLOTS - 1)) ? 4'h0 : cnt_reg + 4'h1;
            end
            lit_next = (cnt_next < 4'(2 * n - 1)) && !cnt_next[0];
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg <= 4'h0;
                lit_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_next;
                lit_reg <= lit_next;
            end
        end
        assign flash[n-1] = lit_reg;
    end

    assign blink   = blink_reg;
    assign flicker = flk_reg;
endmodule
`default_nettype wire

// ==== nsl_led_driver.sv ====
// Front-panel status lamp driver with APB register access
// Behaviour
// - Five lamps: power, one link/activity lamp per port, two red status lamps.
// - Link lamp dark without link, steady with link, flickers on traffic.
// - System lamp dark, steady on system fault, blinks on identify request.
// - Power lamp dark unpowered, green steady, flickers without motor communication.
// - Power lamp steady red while supply too low is reported.
// - Blink: 200 ms on, 200 ms off, 2.5 Hz.
// - Single flash: 200 ms lit then 1 s dark, repeating.
// - Double flash: two flashes on 200 ms period, then 1 s dark.
// - Triple flash: three flashes on 200 ms period, then 1 s dark.
// - Flicker toggles with a period of about 50 ms.
// - System lamp state right after power-up without controller is unspecified.
`timescale 1ns/1ps
`default_nettype none
module nsl_led_driver
    import nsl_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NUM_PORTS-1:0] link_up,
    input  wire logic [NUM_PORTS-1:0] line_activity,
    input  wire logic                 system_fault,
    input  wire logic                 identify_req,
    input  wire logic                 bus_fault,
    input  wire logic                 data_exchange,
    input  wire logic                 module_power,
    input  wire logic                 motor_power,
    input  wire logic                 motor_comm,
    input  wire logic                 supply_low,
    output logic                      link_lamp_one,
    output logic                      link_lamp_two,
    output logic                      system_fault_lamp,
    output logic                      bus_fault_lamp,
    output logic                      power_lamp_green,
    output logic                      power_lamp_red,
    output logic                      irq
);
    localparam int MW = $clog2(MS_CYCLES_P);
    localparam int AW = $clog2(ACT_HOLD_MS + 1);

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
               (a == ADDR_IRQ_MASK) || (a == ADDR_FORCE);
    endfunction

    // Forced mode wins over the automatic choice; auto keeps status-driven behaviour
    function automatic logic pick(input nsl_mode_t m, input logic auto_lvl,
                                  input logic bl, input logic fk,
                                  input logic [NUM_FLASH-1:0] fl);
        logic r;
        r = 1'b0;
        unique case (m)
            MODE_AUTO:    r = auto_lvl;
            MODE_OFF:     r = 1'b0;
            MODE_ON:      r = 1'b1;
            MODE_BLINK:   r = bl;
            MODE_FLASH1:  r = fl[0];
            MODE_FLASH2:  r = fl[1];
            MODE_FLASH3:  r = fl[2];
            MODE_FLICKER: r = fk;
        endcase
        return r;
    endfunction

    // Millisecond enable divider
    logic [MW-1:0] ms_cnt_reg, ms_cnt_next;
    logic          ms_tick_reg, ms_tick_next;

    always_comb begin
        ms_tick_next = (ms_cnt_reg == MW'(MS_CYCLES_P - 1));
        ms_cnt_next  = ms_tick_next ? '0 : ms_cnt_reg + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_reg  <= '0;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_cnt_reg  <= ms_cnt_next;
            ms_tick_reg <= ms_tick_next;
        end
    end

    logic                 pat_blink;
    logic                 pat_flicker;
    logic [NUM_FLASH-1:0] pat_flash;

    nsl_pattern_gen u_pat (
        .pclk    (pclk),
        .presetn (presetn),
        .ms_tick (ms_tick_reg),
        .blink   (pat_blink),
        .flicker (pat_flicker),
        .flash   (pat_flash)
    );

    // Activity is held for one flicker period so a single frame is visible
    logic [NUM_PORTS-1:0] act_seen;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_act
        logic [AW-1:0] hold_reg, hold_next;
        always_comb begin
            hold_next = hold_reg;
            if (line_activity[p] && link_up[p]) begin
                hold_next = AW'(ACT_HOLD_MS);
            end else if (ms_tick_reg && (hold_reg != '0)) begin
                hold_next = hold_reg - 1'b1;
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hold_reg <= '0;
            end else begin
                hold_reg <= hold_next;
            end
        end
        assign act_seen[p] = (hold_reg != '0);
    end

    // Registers
    logic                 ctrl_en_reg, ctrl_en_next;
    logic [IRQ_W-1:0]     irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0]     irq_mask_reg, irq_mask_next;
    logic [FORCE_W-1:0]   force_reg, force_next;
    logic [31:0]          prdata_reg, prdata_next;
    logic                 irq_reg, irq_next;
    logic [NUM_PORTS-1:0] link_prev_reg;
    logic                 sys_prev_reg;
    logic                 bus_prev_reg;
    logic                 uv_prev_reg;
    logic [IRQ_W-1:0]     events;
    logic                 wr_en;
    logic                 rd_setup;
    logic [ST_LAMP_W-1:0] lamps_reg, lamps_next;
    logic [31:0]          status_word;

    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        events = '0;
        events[IRQ_LINK_LSB +: NUM_PORTS] = link_up & ~link_prev_reg;
        events[IRQ_SYS] = system_fault && !sys_prev_reg;
        events[IRQ_BUS] = bus_fault && !bus_prev_reg;
        events[IRQ_UV]  = supply_low && !uv_prev_reg;
    end

    always_comb begin
        status_word = '0;
        status_word[ST_IN_W-1:0] = {supply_low, motor_comm, motor_power, module_power,
                                    data_exchange, bus_fault, identify_req,
                                    system_fault, link_up};
        status_word[ST_LAMP_LSB +: ST_LAMP_W] = lamps_reg;
    end

    always_comb begin
        ctrl_en_next  = ctrl_en_reg;
        irq_mask_next = irq_mask_reg;
        force_next    = force_reg;
        prdata_next   = prdata_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_en) begin
            unique case (paddr)
                ADDR_CTRL:     ctrl_en_next  = pwdata[CTRL_EN_BIT];
                ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: irq_mask_next = pwdata[IRQ_W-1:0];
                ADDR_FORCE:    force_next    = pwdata[FORCE_W-1:0];
                default:       ;
            endcase
        end
        // A new event in the clearing cycle survives the clear
        irq_stat_next = irq_stat_next | events;
        if (rd_setup) begin
            unique case (paddr)
                ADDR_CTRL:     prdata_next = {31'h0, ctrl_en_reg};
                ADDR_STATUS:   prdata_next = status_word;
                ADDR_IRQ_STAT: prdata_next = {27'h0, irq_stat_reg};
                ADDR_IRQ_MASK: prdata_next = {27'h0, irq_mask_reg};
                ADDR_FORCE:    prdata_next = {17'h0, force_reg};
                default:       prdata_next = 32'h0;
            endcase
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    // Lamp selection
    nsl_mode_t mode [NUM_LAMPS];
    logic      auto_link [NUM_PORTS];
    logic      auto_sys;
    logic      auto_bus;
    logic      auto_pwr;

    always_comb begin
        for (int i = 0; i < NUM_LAMPS; i++) begin
            mode[i] = nsl_mode_t'(force_reg[i*MODE_W +: MODE_W]);
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            auto_link[p] = !link_up[p] ? 1'b0 :
                           (act_seen[p] ? pat_flicker : 1'b1);
        end
        // Identify outranks a fault so the unit can still be located
        auto_sys = identify_req ? pat_blink : system_fault;
        auto_bus = bus_fault ? 1'b1 : (data_exchange ? 1'b0 : pat_blink);
        auto_pwr = (motor_power && motor_comm) ? 1'b1 : pat_flicker;
        lamps_next = '0;
        if (ctrl_en_reg) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                lamps_next[LAMP_LINK0 + p] = pick(mode[LAMP_LINK0 + p], auto_link[p],
                                                  pat_blink, pat_flicker, pat_flash);
            end
            lamps_next[LAMP_SYS] = pick(mode[LAMP_SYS], auto_sys,
                                        pat_blink, pat_flicker, pat_flash);
            lamps_next[LAMP_BUS] = pick(mode[LAMP_BUS], auto_bus,
                                        pat_blink, pat_flicker, pat_flash);
            if (module_power) begin
                if (supply_low) begin
                    lamps_next[LAMP_PWR + 1] = 1'b1;
                end else begin
                    lamps_next[LAMP_PWR] = pick(mode[LAMP_PWR], auto_pwr,
                                                pat_blink, pat_flicker, pat_flash);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg   <= CTRL_RESET;
            irq_stat_reg  <= IRQ_RESET;
            irq_mask_reg  <= IRQ_RESET;
            force_reg     <= FORCE_RESET;
            prdata_reg    <= 32'h0;
            irq_reg       <= 1'b0;
            lamps_reg     <= '0;
            link_prev_reg <= '0;
            sys_prev_reg  <= 1'b0;
            bus_prev_reg  <= 1'b0;
            uv_prev_reg   <= 1'b0;
        end else begin
            ctrl_en_reg   <= ctrl_en_next;
            irq_stat_reg  <= irq_stat_next;
            irq_mask_reg  <= irq_mask_next;
            force_reg     <= force_next;
            prdata_reg    <= prdata_next;
            irq_reg       <= irq_next;
            lamps_reg     <= lamps_next;
            link_prev_reg <= link_up;
            sys_prev_reg  <= system_fault;
            bus_prev_reg  <= bus_fault;
            uv_prev_reg   <= supply_low;
        end
    end

    // Zero wait states; read data is fetched in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata  = prdata_reg;
    assign irq     = irq_reg;

    assign link_lamp_one     = lamps_reg[LAMP_LINK0];
    assign link_lamp_two     = lamps_reg[LAMP_LINK0 + 1];
    assign system_fault_lamp = lamps_reg[LAMP_SYS];
    assign bus_fault_lamp    = lamps_reg[LAMP_BUS];
    assign power_lamp_green  = lamps_reg[LAMP_PWR];
    assign power_lamp_red    = lamps_reg[LAMP_PWR + 1];
endmodule
`default_nettype wire

// ==== nsl_led_checker.sv ====
// Port-level assertions for the status lamp driver
`timescale 1ns/1ps
`default_nettype none
module nsl_led_checker
    import nsl_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [NUM_PORTS-1:0] link_up,
    input wire logic                 system_fault,
    input wire logic                 identify_req,
    input wire logic                 bus_fault,
    input wire logic                 data_exchange,
    input wire logic                 module_power,
    input wire logic                 motor_power,
    input wire logic                 motor_comm,
    input wire logic                 supply_low,
    input wire logic                 link_lamp_one,
    input wire logic                 link_lamp_two,
    input wire logic                 system_fault_lamp,
    input wire logic                 bus_fault_lamp,
    input wire logic                 power_lamp_green,
    input wire logic                 power_lamp_red,
    input wire logic                 irq
);
    // Shadow of enable, force and mask, so the link, system, bus and green power rules apply only in auto mode
    logic        en_reg;
    logic [14:0] frc_reg;
    logic [4:0]  msk_reg;
    wire         wr      = psel && penable && pwrite && pready;
    wire         mapped  = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    wire         auto_l1 = en_reg && frc_reg[2:0] == 3'h0;
    wire         auto_sf = en_reg && frc_reg[8:6] == 3'h0;
    wire         auto_bf = en_reg && frc_reg[11:9] == 3'h0;
    wire         auto_pw = en_reg && frc_reg[14:12] == 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'h1;
            frc_reg <= 15'h0000;
            msk_reg <= 5'h00;
        end else if (wr) begin
            if (paddr == ADDR_CTRL) en_reg <= pwdata[0];
            if (paddr == ADDR_FORCE) frc_reg <= pwdata[14:0];
            if (paddr == ADDR_IRQ_MASK) msk_reg <= pwdata[4:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sys_rise; $rose(system_fault) && msk_reg[IRQ_SYS]; endsequence
    property p_irq; s_sys_rise |-> ##[1:3] irq; endproperty
    a_irq: assert property (p_irq) else $error("irq missing after fault");
    property p_slverr; psel && penable && !mapped |-> pslverr; endproperty
    a_slverr: assert property (p_slverr) else $error("no error on unmapped address");
    property p_link_dark; auto_l1 && !link_up[0] |=> !link_lamp_one; endproperty
    a_link_dark: assert property (p_link_dark) else $error("link lamp lit, no link");
    property p_sys_on; auto_sf && !identify_req && system_fault |=> system_fault_lamp; endproperty
    a_sys_on: assert property (p_sys_on) else $error("system lamp dark on fault");
    property p_sys_off; auto_sf && !identify_req && !system_fault |=> !system_fault_lamp; endproperty
    a_sys_off: assert property (p_sys_off) else $error("system lamp lit");
    property p_bus_on; auto_bf && bus_fault |=> bus_fault_lamp; endproperty
    a_bus_on: assert property (p_bus_on) else $error("bus lamp dark on fault");
    property p_bus_off; auto_bf && !bus_fault && data_exchange |=> !bus_fault_lamp; endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus lamp lit");
    property p_force; en_reg && frc_reg[11:9] inside {3'h1, 3'h2}
        |=> bus_fault_lamp == $past(frc_reg[10]); endproperty
    a_force: assert property (p_force) else $error("forced bus lamp wrong");
    property p_pwr_off; !module_power |=> !power_lamp_green && !power_lamp_red; endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("power lamp lit unpowered");
    property p_pwr_red; en_reg && module_power && supply_low
        |=> power_lamp_red && !power_lamp_green; endproperty
    a_pwr_red: assert property (p_pwr_red) else $error("power lamp not red");
    property p_pwr_grn; auto_pw && module_power && !supply_low && motor_power && motor_comm
        |=> power_lamp_green && !power_lamp_red; endproperty
    a_pwr_grn: assert property (p_pwr_grn) else $error("power lamp not green");
    property p_dark; !en_reg |=> {link_lamp_one, link_lamp_two, system_fault_lamp,
        bus_fault_lamp, power_lamp_green, power_lamp_red} == 6'h00; endproperty
    a_dark: assert property (p_dark) else $error("lamp lit while disabled");
endmodule
bind nsl_led_driver nsl_led_checker u_chk (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up), .system_fault(system_fault),
    .identify_req(identify_req), .bus_fault(bus_fault), .data_exchange(data_exchange),
    .module_power(module_power), .motor_power(motor_power), .motor_comm(motor_comm),
    .supply_low(supply_low), .link_lamp_one(link_lamp_one), .link_lamp_two(link_lamp_two),
    .system_fault_lamp(system_fault_lamp), .bus_fault_lamp(bus_fault_lamp),
    .power_lamp_green(power_lamp_green), .power_lamp_red(power_lamp_red), .irq(irq));
`default_nettype wire

// ==== nsl_lamp_watch.sv ====
// Operator model: measures lit and dark run lengths of one lamp
`timescale 1ns/1ps
`default_nettype none
module nsl_lamp_watch (
    input wire logic        pclk,
    input wire logic        lamp,
    input wire logic        arm,
    input wire logic [15:0] min_low,
    output logic            run_done,
    output logic            run_lvl,
    output logic [15:0]     run_len
);
    logic        prev_reg;
    logic        live_reg;
    logic [15:0] cnt_reg;
    // Reporting starts at a rise after a long enough dark run, so flash trains line up
    always @(posedge pclk) begin
        run_done <= 1'b0;
        prev_reg <= lamp;
        cnt_reg <= cnt_reg + 16'h1;
        if (!arm) begin
            live_reg <= 1'b0;
            cnt_reg <= 16'h1;
        end else if (lamp !== prev_reg) begin
            if (live_reg) begin
                run_done <= 1'b1;
                run_lvl <= prev_reg;
                run_len <= cnt_reg;
            end else if (lamp && cnt_reg >= min_low) live_reg <= 1'b1;
            cnt_reg <= 16'h1;
        end
    end
endmodule
`default_nettype wire

// ==== tb_network_status_led_driver.sv ====
// Self-checking bench for the status lamp driver
`timescale 1ns/1ps
`default_nettype none
module tb_network_status_led_driver;
    import nsl_pkg::*;
    localparam int MS = 4;
    localparam int B  = BLINK_HALF_MS * MS;
    localparam int F  = FLICKER_HALF_MS * MS;
    localparam int G  = FLASH_OFF_MS * MS;
    logic pclk, presetn, psel, penable, pwrite, arm, run_done, run_lvl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, m;
    logic pready, pslverr, irq;
    logic [11:0] ins; // Status bit order, activity in [11:10]
    logic l1, l2, sfl, bfl, pg, pr;
    logic [2:0] watch;
    logic [15:0] min_low, run_len;
    logic [31:0] rq[$], mq[$];
    logic [16:0] wq[$];
    int mismatches, checks, cycles;
    wire [5:0] lamps = {pr, pg, bfl, sfl, l2, l1};
    nsl_led_driver #(.MS_CYCLES_P(MS)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_up(ins[1:0]), .line_activity(ins[11:10]),
        .system_fault(ins[2]), .identify_req(ins[3]), .bus_fault(ins[4]),
        .data_exchange(ins[5]), .module_power(ins[6]), .motor_power(ins[7]),
        .motor_comm(ins[8]), .supply_low(ins[9]), .link_lamp_one(l1),
        .link_lamp_two(l2), .system_fault_lamp(sfl), .bus_fault_lamp(bfl),
        .power_lamp_green(pg), .power_lamp_red(pr), .irq(irq));
    nsl_lamp_watch u_eye (.pclk(pclk), .lamp(lamps[watch]), .arm(arm), .min_low(min_low),
        .run_done(run_done), .run_lvl(run_lvl), .run_len(run_len));
    always #50 pclk = ~pclk;
    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic report(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_rd(input logic [31:0] e, input logic [31:0] g);
        report("prdata", e, g);
    endtask
    task automatic check_run(input logic [16:0] e, input logic [16:0] g);
        report("lamp run", 32'(e), 32'(g));
    endtask
    // Falling edge: irq has settled
    task automatic check_irq(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        report("irq", 32'(e), 32'(irq));
        @(posedge pclk);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        rq.push_back(e);
        mq.push_back(k);
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic run_pat(input int idx, input int n, input int lo, input int gap,
        input int sync);
        watch <= 3'(idx);
        min_low <= 16'(sync);
        for (int i = 0; i < n; i++) begin
            wq.push_back({1'b1, 16'(lo)});
            wq.push_back({1'b0, 16'(i == n - 1 ? gap : lo)});
        end
        // Watcher must see the new lamp once before arming
        @(posedge pclk);
        arm <= 1'b1;
        @(posedge pclk);
        while (wq.size() > 0) @(posedge pclk);
        arm <= 1'b0;
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            m = mq.pop_front();
            check_rd(rq.pop_front() & m, prdata & m);
        end
        if (run_done === 1'b1) check_run(wq.pop_front(), {run_lvl, run_len});
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, arm, paddr, pwdata, watch, min_low, ins} = '0;
        void'($urandom(32'h475a));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, 32'h1, '1);
        rd(ADDR_IRQ_STAT, 32'h0, '1);
        rd(ADDR_IRQ_MASK, 32'h0, '1);
        rd(ADDR_FORCE, 32'h0, '1);
        rd(8'h14, 32'h0, '1);
        // Random inputs and modes exercise the assertions
        repeat (40) begin
            ins <= 12'($urandom);
            wr(ADDR_FORCE, $urandom & 32'h7fff);
            wr(ADDR_CTRL, $urandom & 32'h1);
            rd(ADDR_STATUS, {22'h0, ins[9:0]}, 32'h3ff);
        end
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_FORCE, 32'h0);
        // Both links busy, identify on, no data exchange, motor silent
        ins <= 12'hccb;
        @(posedge pclk);
        run_pat(0, 2, F, F, 0);
        run_pat(1, 2, F, F, 0);
        run_pat(2, 2, B, B, 0);
        run_pat(3, 2, B, B, 0);
        run_pat(4, 2, F, F, 0);
        for (int n = 1; n <= 3; n++) begin
            wr(ADDR_FORCE, 32'(MODE_FLASH1 + n - 1) << 9);
            run_pat(3, n, B, G, G);
        end
        wr(ADDR_FORCE, 32'(MODE_FLICKER) << 9);
        run_pat(3, 2, F, F, 0);
        wr(ADDR_IRQ_STAT, 32'h1f);
        rd(ADDR_IRQ_STAT, 32'h0, '1);
        wr(ADDR_IRQ_MASK, 32'h4);
        ins[2] <= 1'b1;
        check_irq(1'b1);
        rd(ADDR_IRQ_STAT, 32'h4, '1);
        wr(ADDR_IRQ_MASK, 32'h0);
        check_irq(1'b0);
        wr(ADDR_IRQ_MASK, 32'h4);
        check_irq(1'b1);
        wr(ADDR_IRQ_STAT, 32'h4);
        check_irq(1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
